// ---- pd_regs_pkg.sv ----
// constants for the port-capability and receive-configuration register slice
package pd_regs_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] CAP_ONE_HIGH_ADDR = 8'h25;
   localparam logic [7:0] CAP_TWO_LOW_ADDR = 8'h26;
   localparam logic [7:0] CAP_TWO_HIGH_ADDR = 8'h27;
   localparam logic [7:0] STANDARD_OUTPUT_CAPABILITIES_ADDR = 8'h29;
   localparam logic [7:0] HEADER_TEMPLATE_ADDR = 8'h2e;
   localparam logic [7:0] RX_ENABLES_ADDR = 8'h2f;
   localparam logic [7:0] RX_BYTE_COUNT_ADDR = 8'h30;
   // ----------------------------------------
   // fixed values and reset values
   // ----------------------------------------
   localparam logic [7:0] CAP_ONE_HIGH_VALUE = 8'h1e;
   localparam logic [7:0] CAP_TWO_LOW_VALUE = 8'hd7;
   localparam logic [7:0] CAP_TWO_HIGH_VALUE = 8'h01;
   localparam logic [7:0] STANDARD_OUTPUT_CAPABILITIES_VALUE = 8'h05;
   localparam logic [7:0] HEADER_TEMPLATE_RESET = 8'h0b;
   localparam logic [7:0] RX_ENABLES_RESET = 8'h00;
   localparam logic [7:0] BYTE_COUNT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // ----------------------------------------
   // field layouts
   // ----------------------------------------
   localparam logic [7:0] HEADER_WRITE_MASK = 8'h1f;
   localparam logic [7:0] RX_ENABLES_WRITE_MASK = 8'h3f;
   localparam logic [7:0] SOP_KIND_MASK = 8'h1f;
   localparam int HARD_RESET_BIT = 5;
   localparam int CABLE_RESET_BIT = 6;
   localparam int CABLE_ORIGIN_BIT = 4;
   localparam int DATA_ROLE_BIT = 3;
   localparam int REV_LSB = 1;
   localparam int POWER_ROLE_BIT = 0;
   localparam logic [1:0] REV_ONE = 2'h0;
   localparam logic [1:0] REV_TWO = 2'h1;
   localparam logic [1:0] RP_DEFAULT_ONLY = 2'h0;
   localparam logic [1:0] RP_ONE_FIVE = 2'h1;
   localparam logic [1:0] RP_THREE = 2'h2;
   localparam logic [1:0] ALARM_STEP_50MV = 2'h1;
   localparam logic [2:0] CABLE_POWER_3W = 3'h3;
   localparam logic [7:0] COUNT_OVERHEAD = 8'h03;
   // ----------------------------------------
   // one-more-receive arming states
   // ----------------------------------------
   typedef enum logic [0:0] {ARM_IDLE, ARM_WAIT_ACK} arm_state_t;
endpackage : pd_regs_pkg

// ---- pd_capability_rom.sv ----
// read-only capability words of the port
module pd_capability_rom (
   input wire logic [7:0] addr,
   output logic hit,
   output logic [7:0] value
);
   // ----------------------------------------
   // fixed capability decode
   // ----------------------------------------
   wire logic hitOneHigh = (addr == pd_regs_pkg::CAP_ONE_HIGH_ADDR);
   wire logic hitTwoLow = (addr == pd_regs_pkg::CAP_TWO_LOW_ADDR);
   wire logic hitTwoHigh = (addr == pd_regs_pkg::CAP_TWO_HIGH_ADDR);
   wire logic hitStdOut = (addr == pd_regs_pkg::STANDARD_OUTPUT_CAPABILITIES_ADDR);
   assign hit = hitOneHigh | hitTwoLow | hitTwoHigh | hitStdOut;
   // constants only, so a write can never alter them
   assign value = hitOneHigh ? pd_regs_pkg::CAP_ONE_HIGH_VALUE :
                  hitTwoLow ? pd_regs_pkg::CAP_TWO_LOW_VALUE :
                  hitTwoHigh ? pd_regs_pkg::CAP_TWO_HIGH_VALUE :
                  hitStdOut ? pd_regs_pkg::STANDARD_OUTPUT_CAPABILITIES_VALUE :
                  pd_regs_pkg::UNMAPPED_READ;
endmodule : pd_capability_rom

// ---- pd_port_caps_and_rx_config_regs.sv ----
// capability, header-template and receive-enable register slice
// What this block does
// - receive enables bits 0-5 writable
// - enabled sop kinds get automatic goodcrc reply
// - hard reset sent or received clears enables
// - one-more-receive clears enables after next goodcrc
// - disconnect, software reset, power-on clear enables
// - all enables zero means no reception
// - cable reset enable reads zero always
// - byte count is payload bytes plus three
// - header template cable, data, power role bits
// - revision field 00 rev1, 01 rev2
// - alarm resolution reads 50 mV step
// - capability one high reports discharge, measure, current
// - source current field encodings fixed
// - capability two low thresholds and 3 W
// - capability two high reads watchdog only
// - standard outputs capability reads 0x05
module pd_port_caps_and_rx_config_regs #(
   parameter int PAYLOAD_MAX = 28
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic hardResetRx,
   input wire logic hardResetTx,
   input wire logic disconnectDetect,
   input wire logic softwareResetRequest,
   input wire logic oneMoreReceiveCommand,
   input wire logic goodCrcSent,
   input wire logic msgAccepted,
   input wire logic [2:0] msgSopKind,
   input wire logic payloadStored,
   input wire logic [7:0] payloadBytes,
   output logic [7:0] rxEnables,
   output logic receiveActive,
   output logic hardResetDetectEnable,
   output logic goodCrcRequest,
   output logic [2:0] goodCrcSopKind,
   output logic cableOriginFlag,
   output logic dataRole,
   output logic [1:0] protocolRevision,
   output logic powerRole
);
   // count plus its three overhead bytes must still fit the eight-bit register
   if (PAYLOAD_MAX < 1 || PAYLOAD_MAX > 252) begin : g_depth_check
      $error("payload depth out of range");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] headerReg;
   logic [7:0] headerNext;
   logic [7:0] enablesReg;
   logic [7:0] enablesNext;
   logic [7:0] countReg;
   logic [7:0] countNext;
   logic goodCrcReg;
   logic goodCrcNext;
   logic [2:0] goodCrcKindReg;
   logic [2:0] goodCrcKindNext;
   pd_regs_pkg::arm_state_t armReg;
   pd_regs_pkg::arm_state_t armNext;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire logic romHit;
   wire logic [7:0] romValue;
   pd_capability_rom u_rom (
      .addr(regAddr),
      .hit(romHit),
      .value(romValue)
   );
   wire logic hitHeader = (regAddr == pd_regs_pkg::HEADER_TEMPLATE_ADDR);
   wire logic hitEnables = (regAddr == pd_regs_pkg::RX_ENABLES_ADDR);
   wire logic hitCount = (regAddr == pd_regs_pkg::RX_BYTE_COUNT_ADDR);
   wire logic writeHeader = regWrite & hitHeader;
   wire logic writeEnables = regWrite & hitEnables;
   wire logic [7:0] readMux = romHit ? romValue :
                              hitHeader ? headerReg :
                              hitEnables ? enablesReg :
                              hitCount ? countReg :
                              pd_regs_pkg::UNMAPPED_READ;

   // ----------------------------------------
   // clearing events
   // ----------------------------------------
   wire logic hardResetSeen = hardResetRx | hardResetTx;
   wire logic oneMoreDone = (armReg == pd_regs_pkg::ARM_WAIT_ACK) & goodCrcSent;
   wire logic clearEnables = hardResetSeen | oneMoreDone | disconnectDetect
                           | softwareResetRequest;
   // a message of a kind that is switched on, and only while reception runs
   wire logic kindEnabled = (int'(msgSopKind) < pd_regs_pkg::HARD_RESET_BIT)
                          & enablesReg[msgSopKind];
   wire logic acceptNow = msgAccepted & receiveActive & kindEnabled;

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      headerNext = headerReg;
      // reserved upper bits stay zero
      if (writeHeader) begin
         headerNext = regWdata & pd_regs_pkg::HEADER_WRITE_MASK;
      end
      enablesNext = enablesReg;
      // clearing wins over a write in the same cycle: hardware must stop reception
      if (clearEnables) begin
         enablesNext = pd_regs_pkg::RX_ENABLES_RESET;
      end else if (writeEnables) begin
         enablesNext = regWdata & pd_regs_pkg::RX_ENABLES_WRITE_MASK;
      end
      armNext = armReg;
      case (armReg)
         pd_regs_pkg::ARM_IDLE: begin
            if (oneMoreReceiveCommand && !clearEnables) begin
               armNext = pd_regs_pkg::ARM_WAIT_ACK;
            end
         end
         pd_regs_pkg::ARM_WAIT_ACK: begin
            if (clearEnables) begin
               armNext = pd_regs_pkg::ARM_IDLE;
            end
         end
         default: armNext = pd_regs_pkg::ARM_IDLE;
      endcase
      countNext = countReg;
      if (softwareResetRequest) begin
         countNext = pd_regs_pkg::BYTE_COUNT_RESET;
      end else if (payloadStored && payloadBytes <= 8'(PAYLOAD_MAX)) begin
         countNext = payloadBytes + pd_regs_pkg::COUNT_OVERHEAD;
      end
      goodCrcNext = acceptNow;
      goodCrcKindNext = acceptNow ? msgSopKind : goodCrcKindReg;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         headerReg <= pd_regs_pkg::HEADER_TEMPLATE_RESET;
         enablesReg <= pd_regs_pkg::RX_ENABLES_RESET;
         countReg <= pd_regs_pkg::BYTE_COUNT_RESET;
         goodCrcReg <= 1'b0;
         goodCrcKindReg <= 3'h0;
         armReg <= pd_regs_pkg::ARM_IDLE;
         regRdata <= pd_regs_pkg::UNMAPPED_READ;
      end else begin
         headerReg <= headerNext;
         enablesReg <= enablesNext;
         countReg <= countNext;
         goodCrcReg <= goodCrcNext;
         goodCrcKindReg <= goodCrcKindNext;
         armReg <= armNext;
         if (regRead) begin
            regRdata <= readMux;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rxEnables = enablesReg;
   assign receiveActive = (enablesReg != pd_regs_pkg::RX_ENABLES_RESET);
   assign hardResetDetectEnable = enablesReg[pd_regs_pkg::HARD_RESET_BIT];
   assign goodCrcRequest = goodCrcReg;
   assign goodCrcSopKind = goodCrcKindReg;
   assign cableOriginFlag = headerReg[pd_regs_pkg::CABLE_ORIGIN_BIT];
   assign dataRole = headerReg[pd_regs_pkg::DATA_ROLE_BIT];
   assign protocolRevision = headerReg[pd_regs_pkg::REV_LSB +: 2];
   assign powerRole = headerReg[pd_regs_pkg::POWER_ROLE_BIT];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_write_enables;
      @(posedge clock) disable iff (!nrst)
      (writeEnables && !clearEnables) |=> (rxEnables == ($past(regWdata) & 8'h3f));
   endproperty
   a_write_enables: assert property (p_write_enables) else $error("enable write lost");

   property p_goodcrc;
      @(posedge clock) disable iff (!nrst)
      (msgAccepted && rxEnables[msgSopKind] && msgSopKind <= 3'h4) |=>
         (goodCrcRequest && goodCrcSopKind == $past(msgSopKind));
   endproperty
   a_goodcrc: assert property (p_goodcrc) else $error("no goodcrc reply");

   property p_hard_reset_clear;
      @(posedge clock) disable iff (!nrst)
      (hardResetRx || hardResetTx) |=> (rxEnables == 8'h00);
   endproperty
   a_hard_reset_clear: assert property (p_hard_reset_clear) else $error("hard reset kept enables");

   property p_one_more;
      @(posedge clock) disable iff (!nrst)
      ((oneMoreReceiveCommand && !clearEnables) ##1 (!clearEnables && !goodCrcSent) [*3]
         ##1 goodCrcSent) |=> (rxEnables == 8'h00);
   endproperty
   a_one_more: assert property (p_one_more) else $error("one-more not honoured");

   property p_other_clear;
      @(posedge clock) disable iff (!nrst)
      (disconnectDetect || softwareResetRequest) |=> (rxEnables == 8'h00);
   endproperty
   a_other_clear: assert property (p_other_clear) else $error("enables not cleared");

   property p_no_rx_when_off;
      @(posedge clock) disable iff (!nrst)
      (rxEnables == 8'h00) |=> !goodCrcRequest;
   endproperty
   a_no_rx_when_off: assert property (p_no_rx_when_off) else $error("reply while off");

   property p_cable_bit;
      @(posedge clock) disable iff (!nrst)
      regWrite ##1 1'b1 |-> (rxEnables[7:6] == 2'b00 && headerReg[7:5] == 3'h0);
   endproperty
   a_cable_bit: assert property (p_cable_bit) else $error("read-only bit set");

   property p_count;
      @(posedge clock) disable iff (!nrst)
      (payloadStored && !softwareResetRequest && payloadBytes <= 8'(PAYLOAD_MAX))
         |=> (countReg == $past(payloadBytes) + 8'h03);
   endproperty
   a_count: assert property (p_count) else $error("byte count wrong");

   property p_cap_read;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == 8'h29) |=> (regRdata == 8'h05);
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("output capability wrong");

   property p_write_header;
      @(posedge clock) disable iff (!nrst)
      writeHeader |=> (headerReg == ($past(regWdata) & pd_regs_pkg::HEADER_WRITE_MASK));
   endproperty
   a_write_header: assert property (p_write_header) else $error("header write lost");

   property p_header_hold;
      @(posedge clock) disable iff (!nrst)
      !writeHeader |=> $stable(headerReg);
   endproperty
   a_header_hold: assert property (p_header_hold) else $error("header changed unasked");

   property p_enables_hold;
      @(posedge clock) disable iff (!nrst)
      (!writeEnables && !clearEnables) |=> $stable(rxEnables);
   endproperty
   a_enables_hold: assert property (p_enables_hold) else $error("enables changed unasked");

   property p_rev_field;
      @(posedge clock) disable iff (!nrst)
      writeHeader |=> (protocolRevision == $past(regWdata[pd_regs_pkg::REV_LSB +: 2]));
   endproperty
   a_rev_field: assert property (p_rev_field) else $error("revision field wrong");

   property p_role_ports;
      @(posedge clock) disable iff (!nrst)
      writeHeader |=> (cableOriginFlag == $past(regWdata[pd_regs_pkg::CABLE_ORIGIN_BIT])
         && dataRole == $past(regWdata[pd_regs_pkg::DATA_ROLE_BIT])
         && powerRole == $past(regWdata[pd_regs_pkg::POWER_ROLE_BIT]));
   endproperty
   a_role_ports: assert property (p_role_ports) else $error("role fields wrong");

   property p_cap_one_high;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == pd_regs_pkg::CAP_ONE_HIGH_ADDR)
         |=> (regRdata == pd_regs_pkg::CAP_ONE_HIGH_VALUE);
   endproperty
   a_cap_one_high: assert property (p_cap_one_high) else $error("capability one wrong");

   property p_source_current;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == pd_regs_pkg::CAP_ONE_HIGH_ADDR)
         |=> (regRdata[1:0] == pd_regs_pkg::RP_THREE);
   endproperty
   a_source_current: assert property (p_source_current) else $error("current code wrong");

   property p_cap_two_low;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == pd_regs_pkg::CAP_TWO_LOW_ADDR)
         |=> (regRdata[7:6] == 2'b11 && regRdata[3:1] == pd_regs_pkg::CABLE_POWER_3W);
   endproperty
   a_cap_two_low: assert property (p_cap_two_low) else $error("capability two low wrong");

   property p_alarm_step;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == pd_regs_pkg::CAP_TWO_LOW_ADDR)
         |=> (regRdata[5:4] == pd_regs_pkg::ALARM_STEP_50MV);
   endproperty
   a_alarm_step: assert property (p_alarm_step) else $error("alarm step wrong");

   property p_cap_two_high;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == pd_regs_pkg::CAP_TWO_HIGH_ADDR)
         |=> (regRdata == pd_regs_pkg::CAP_TWO_HIGH_VALUE);
   endproperty
   a_cap_two_high: assert property (p_cap_two_high) else $error("capability two high wrong");

   property p_count_read;
      @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == pd_regs_pkg::RX_BYTE_COUNT_ADDR)
         |=> (regRdata == $past(countReg));
   endproperty
   a_count_read: assert property (p_count_read) else $error("byte count read wrong");

   property p_refused_msg;
      @(posedge clock) disable iff (!nrst)
      (msgAccepted && !(msgSopKind <= 3'h4 && rxEnables[msgSopKind]))
         |=> !goodCrcRequest;
   endproperty
   a_refused_msg: assert property (p_refused_msg) else $error("reply to refused message");

   property p_cable_reset_off;
      @(posedge clock) disable iff (!nrst)
      writeEnables |=> !rxEnables[pd_regs_pkg::CABLE_RESET_BIT];
   endproperty
   a_cable_reset_off: assert property (p_cable_reset_off) else $error("cable reset enabled");
endmodule : pd_port_caps_and_rx_config_regs

// ---- pd_port_manager_model.sv ----
// port manager model: register bus master and command source
module pd_port_manager_model (
   input wire logic clock,
   input wire logic [7:0] regRdata,
   output logic [7:0] regAddr,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regWdata,
   output logic oneMoreReceiveCommand
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWdata = 8'h00;
      oneMoreReceiveCommand = 1'b0;
   end
   // ----------------------------------------
   // bus cycles, one strobe cycle each
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      regWdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   // stop reception at a known point
   task automatic stopAfterNext();
      @(posedge clock);
      oneMoreReceiveCommand <= 1'b1;
      @(posedge clock);
      oneMoreReceiveCommand <= 1'b0;
   endtask : stopAfterNext
endmodule : pd_port_manager_model

// ---- pd_port_caps_and_rx_config_regs_test.sv ----
// self-checking bench for the capability and receive-config registers
module pd_port_caps_and_rx_config_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [6:0] ev = 7'h00;
   logic [2:0] msgSopKind = 3'h0;
   logic [7:0] payloadBytes = 8'h00;
   logic [7:0] regAddr, regWdata, regRdata, rxEnables;
   logic regWrite, regRead, oneMore, receiveActive, hrEnable, crcReq;
   logic [2:0] crcKind;
   logic cOrigin, dRole, pRole;
   logic [1:0] rev;
   int errorCnt = 0;
   int compares = 0;
   always #2 clock = ~clock;
   pd_port_manager_model pm (.clock(clock), .regRdata(regRdata), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .oneMoreReceiveCommand(oneMore));
   pd_port_caps_and_rx_config_regs DUT (.clock(clock), .nrst(nrst), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .hardResetRx(ev[6]), .hardResetTx(ev[5]), .disconnectDetect(ev[4]),
      .softwareResetRequest(ev[3]), .oneMoreReceiveCommand(oneMore), .goodCrcSent(ev[2]),
      .msgAccepted(ev[1]), .msgSopKind(msgSopKind), .payloadStored(ev[0]),
      .payloadBytes(payloadBytes), .rxEnables(rxEnables), .receiveActive(receiveActive),
      .hardResetDetectEnable(hrEnable), .goodCrcRequest(crcReq), .goodCrcSopKind(crcKind),
      .cableOriginFlag(cOrigin), .dataRole(dRole), .protocolRevision(rev),
      .powerRole(pRole));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // one-cycle pulse on event input k, returns once its effect has landed
   task automatic pulse(input int k);
      @(posedge clock);
      ev <= 7'h01 << k;
      @(posedge clock);
      ev <= 7'h00;
      #1;
   endtask : pulse
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      pm.rd(a, d);
      chk("read data", d, exp);
   endtask : rdChk
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic capsTest();
      logic [7:0] adr [8] = '{8'h25, 8'h26, 8'h27, 8'h29, 8'h30, 8'h28, 8'h2e, 8'h2f};
      logic [7:0] val [8] = '{8'h1e, 8'hd7, 8'h01, 8'h05, 8'h00, 8'h00, 8'h0b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rdChk(adr[i], val[i]);
         if (i < 6) begin
            pm.wr(adr[i], 8'hff);
            rdChk(adr[i], val[i]);
         end
      end
      chk("header ports", {3'h0, cOrigin, dRole, rev, pRole}, 8'h0b);
   endtask : capsTest
   task automatic headerTest();
      pm.wr(8'h2e, 8'hf5);
      rdChk(8'h2e, 8'h15);
      chk("header ports", {3'h0, cOrigin, dRole, rev, pRole}, 8'h15);
      pm.wr(8'h2e, 8'h02);
      #1 chk("header ports", {3'h0, cOrigin, dRole, rev, pRole}, 8'h02);
   endtask : headerTest
   task automatic msg(input logic [2:0] k, input logic exp);
      @(posedge clock);
      msgSopKind <= k;
      ev <= 7'h02;
      @(posedge clock);
      ev <= 7'h00;
      #1 chk("reply request", {7'h0, crcReq}, {7'h0, exp});
      if (exp) chk("reply kind", {5'h0, crcKind}, {5'h0, k});
      @(posedge clock);
      #1 chk("reply request end", {7'h0, crcReq}, 8'h00);
   endtask : msg
   task automatic rxTest();
      pm.wr(8'h2f, 8'hff);
      rdChk(8'h2f, 8'h3f);
      chk("hard reset enable", {7'h0, hrEnable}, 8'h01);
      chk("receive active", {7'h0, receiveActive}, 8'h01);
      for (int k = 0; k < 6; k++) msg(k[2:0], k < 5);
      pm.wr(8'h2f, 8'h01);
      msg(3'h1, 1'b0);
      chk("hard reset enable", {7'h0, hrEnable}, 8'h00);
      pm.wr(8'h2f, 8'h00);
      #1 chk("receive active", {7'h0, receiveActive}, 8'h00);
      msg(3'h0, 1'b0);
   endtask : rxTest
   task automatic clearTest();
      for (int k = 3; k < 7; k++) begin
         pm.wr(8'h2f, 8'h3f);
         #1 chk("enables set", rxEnables, 8'h3f);
         pulse(k);
         chk("enables cleared", rxEnables, 8'h00);
      end
      fork
         pm.wr(8'h2f, 8'h3f);
         pulse(4);
      join
      chk("clear beats write", rxEnables, 8'h00);
   endtask : clearTest
   task automatic oneMoreTest();
      pm.wr(8'h2f, 8'h3f);
      pulse(2);
      chk("enables kept unarmed", rxEnables, 8'h3f);
      pm.stopAfterNext();
      pulse(0);
      chk("enables armed", rxEnables, 8'h3f);
      pulse(2);
      chk("enables after reply", rxEnables, 8'h00);
   endtask : oneMoreTest
   task automatic countTest();
      payloadBytes <= 8'h1c;
      pulse(0);
      rdChk(8'h30, 8'h1f);
      payloadBytes <= 8'h1d;
      pulse(0);
      rdChk(8'h30, 8'h1f);
      pulse(3);
      rdChk(8'h30, 8'h00);
   endtask : countTest
   task automatic resetTest();
      pm.wr(8'h2e, 8'h10);
      pm.wr(8'h2f, 8'h3f);
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      #1 chk("enables after reset", rxEnables, 8'h00);
      chk("header after reset", {3'h0, cOrigin, dRole, rev, pRole}, 8'h0b);
      rdChk(8'h2e, 8'h0b);
   endtask : resetTest
   task automatic summarize();
      if (errorCnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      capsTest();
      headerTest();
      rxTest();
      clearTest();
      oneMoreTest();
      countTest();
      resetTest();
      summarize();
   end
endmodule : pd_port_caps_and_rx_config_regs_test
